/* rtl/twd_timer_watchdog.sv */
// Timer/watchdog with 8-bit prescaler, 16-bit down counter and pin output.

// Overview of operation
// [RQ1] Four dedicated registers: count high, count low, prescale, control, all one page.
// [RQ2] Counter bytes can be read and written while the counter runs.
// [RQ3] Prescale value plus one sets the division: 00h by 1, FFh by 256.
// [RQ4] Software loads prescaler and counter bytes before starting the counter.
// [RQ5] Control bit 7 starts counting when 1, stops when 0; reads 0 after reset.
// [RQ6] Control bit 6 selects single count when 1, continuous when 0.
// [RQ7] Bits 5:4 select input pin mode; bit 3 enables the input section.
// [RQ8] Modes: 00 events, 01 gated high, 11 retrigger start, 10 restart while running.
// [RQ9] Output mode 1 copies user bit at end of count; 0 toggles the pin.
// [RQ10] Control bit 1 is a software writable output value, resets to 1.
// [RQ11] Control bit 0 enables the selected output function.
// [RQ12] With output disabled the pin is held high.
// [RQ13] Clearing the active-low watchdog enable enters watchdog mode; cannot be set again.
// [RQ14] Watchdog end of count resets system; AAh then 55h to count low reloads.
// [RQ15] Top-level select 0 routes timer end of count, 1 routes external pin.
// [RQ16] Channel select routes timer interrupt through external channel zero.
// [RQ17] Software changes channel select only with interrupts disabled and pending cleared.
// [RQ18] Outside watchdog mode, each end of count raises an interrupt request.
// [RQ19] Counter decrements per prescaler tick; prescaler fed by clock/4 or pin events.
module twd_timer_watchdog
  import twd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire twd_bus_type bus,
  output logic [7:0] rdata,
  input wire logic timer_in,
  input wire logic nmi_pin,
  input wire logic ext_int0_pin,
  output logic timer_out,
  output twd_event_type events
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [7:0] reload_high, reload_low, prescale, control, wait_ctl, ext_int_vector_select;
  logic [7:0] next_reload_high, next_reload_low, next_prescale, next_control, next_wait_ctl, next_ext_int_vector_select;
  logic [15:0] count, next_count;
  logic [7:0] pre_count, next_pre_count;
  logic [1:0] div4, next_div4;
  logic reload_pending, next_reload_pending;
  logic refresh_armed, next_refresh_armed;
  logic in_prev, next_in_prev;
  logic out_level, next_out_level;
  logic eoc_q, next_eoc_q;
  logic [7:0] rdata_q, next_rdata_q;

  // ----------------------------------------
  // Combinational decode
  // ----------------------------------------
  logic wdog_mode, int_tick, in_fall, src_tick, count_en, eoc;
  logic [1:0] in_mode;
  logic in_en, running;

  function automatic logic hit(input twd_bus_type b, input logic [7:0] a);
    return b.wr && (b.addr == a);
  endfunction

  assign wdog_mode = ~wait_ctl[WCR_WATCHDOG_ENABLE_N];
  assign in_mode = control[CTL_INPUT_MODE_HI:CTL_INPUT_MODE_LO];
  // Watchdog mode ignores the input section and forces continuous running
  assign in_en = control[CTL_INPUT_ENABLE] & ~wdog_mode; // RQ7
  assign running = control[CTL_RUN_STOP] | wdog_mode; // RQ5
  assign int_tick = (div4 == INTERNAL_CLOCK_DIV_LAST);
  assign in_fall = in_prev & ~timer_in;

  // Prescaler source: pin events in event mode, internal clock / 4 while the pin is high in gated mode, else internal clock / 4
  always_comb begin
    src_tick = int_tick; // RQ19
    if (in_en) begin
      case (in_mode)
        IN_EVENT: src_tick = in_fall; // RQ8
        IN_GATED: src_tick = int_tick & timer_in; // RQ8
        default: src_tick = int_tick;
      endcase
    end
  end

  assign count_en = running & src_tick & (pre_count == 8'h00);
  assign eoc = count_en & (count == 16'h0000); // RQ19

  // ----------------------------------------
  // Register, counter and output next state
  // ----------------------------------------
  always_comb begin
    next_reload_high = reload_high;
    next_reload_low = reload_low;
    next_prescale = prescale;
    next_control = control;
    next_wait_ctl = wait_ctl;
    next_ext_int_vector_select = ext_int_vector_select;
    next_count = count;
    next_pre_count = pre_count;
    next_div4 = div4 + 2'h1;
    next_reload_pending = reload_pending;
    next_refresh_armed = refresh_armed;
    next_in_prev = timer_in;
    next_out_level = out_level;
    next_eoc_q = eoc;

    // Prescaler divides by value plus one
    if (running && src_tick) begin
      if (pre_count == 8'h00) begin
        next_pre_count = prescale; // RQ3
      end else begin
        next_pre_count = pre_count - 8'h01;
      end
    end

    // Down count; end of count reloads the constant
    if (eoc) begin
      next_count = {reload_high, reload_low}; // RQ19
      next_reload_pending = 1'b0;
      if (control[CTL_SINGLE_CONTINUOUS] && !wdog_mode) begin
        next_control[CTL_RUN_STOP] = 1'b0; // RQ6
      end
      // Square wave toggles, PWM copies the user bit
      if (control[CTL_OUTPUT_MODE]) begin
        next_out_level = control[CTL_USER_OUTPUT_VALUE]; // RQ9
      end else begin
        next_out_level = ~out_level; // RQ9
      end
    end else if (count_en) begin
      next_count = count - 16'h0001; // RQ19
    end

    // Pin triggers: restart while running, or start and reload
    if (in_en && in_fall) begin
      if (in_mode == IN_TRIGGER && control[CTL_RUN_STOP]) begin
        next_count = {reload_high, reload_low}; // RQ8
        next_pre_count = prescale;
      end else if (in_mode == IN_RETRIGGER) begin
        next_control[CTL_RUN_STOP] = 1'b1; // RQ8
        next_count = {reload_high, reload_low};
        next_pre_count = prescale;
      end
    end

    // A stopped counter takes a constant written while stopped
    if (!running && reload_pending) begin
      next_count = {reload_high, reload_low};
      next_reload_pending = 1'b0;
    end

    // Register writes; counter keeps running meanwhile
    if (hit(bus, ADDR_TIMER_COUNT_HIGH) && !wdog_mode) begin
      next_reload_high = bus.wdata; // RQ2
      next_reload_pending = 1'b1;
    end
    if (hit(bus, ADDR_TIMER_COUNT_LOW)) begin
      if (wdog_mode) begin
        // Refresh: AAh arms, 55h right after reloads and restarts
        if (bus.wdata == REFRESH_SECOND && refresh_armed) begin
          next_count = {reload_high, reload_low}; // RQ14
          next_pre_count = prescale;
        end
        next_refresh_armed = (bus.wdata == REFRESH_FIRST); // RQ14
      end else begin
        next_reload_low = bus.wdata; // RQ2
        next_reload_pending = 1'b1;
      end
    end
    if (hit(bus, ADDR_TIMER_PRESCALE)) begin
      next_prescale = bus.wdata; // RQ3
    end
    if (hit(bus, ADDR_TIMER_CONTROL)) begin
      // Single-count stop by hardware loses to a same-cycle software write
      next_control = bus.wdata; // RQ5
    end
    if (hit(bus, ADDR_WAIT_CONTROL)) begin
      // Only a clear of the enable sticks; ones are ignored
      next_wait_ctl = bus.wdata;
      next_wait_ctl[WCR_WATCHDOG_ENABLE_N] = wait_ctl[WCR_WATCHDOG_ENABLE_N] & bus.wdata[WCR_WATCHDOG_ENABLE_N]; // RQ13
    end
    if (hit(bus, ADDR_EXT_INT_VECTOR_SELECT)) begin
      next_ext_int_vector_select = bus.wdata; // RQ16
    end
  end

  // ----------------------------------------
  // Read data, registered
  // ----------------------------------------
  always_comb begin
    next_rdata_q = 8'h00;
    if (bus.rd) begin
      case (bus.addr)
        ADDR_TIMER_COUNT_HIGH: next_rdata_q = count[15:8]; // RQ2
        ADDR_TIMER_COUNT_LOW: next_rdata_q = count[7:0]; // RQ2
        ADDR_TIMER_PRESCALE: next_rdata_q = prescale;
        ADDR_TIMER_CONTROL: next_rdata_q = control;
        ADDR_WAIT_CONTROL: next_rdata_q = wait_ctl;
        ADDR_EXT_INT_VECTOR_SELECT: next_rdata_q = ext_int_vector_select;
        default: next_rdata_q = 8'h00; // RQ1
      endcase
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      reload_high <= RST_UNDEFINED; // RQ4
      reload_low <= RST_UNDEFINED;
      prescale <= RST_UNDEFINED;
      control <= RST_TIMER_CONTROL; // RQ10
      wait_ctl <= RST_WAIT_CONTROL; // RQ13
      ext_int_vector_select <= RST_EXT_INT_VECTOR_SELECT;
      count <= 16'h0000;
      pre_count <= 8'h00;
      div4 <= 2'h0;
      reload_pending <= 1'b0;
      refresh_armed <= 1'b0;
      in_prev <= 1'b1;
      out_level <= 1'b1;
      eoc_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      reload_high <= next_reload_high;
      reload_low <= next_reload_low;
      prescale <= next_prescale;
      control <= next_control;
      wait_ctl <= next_wait_ctl;
      ext_int_vector_select <= next_ext_int_vector_select;
      count <= next_count;
      pre_count <= next_pre_count;
      div4 <= next_div4;
      reload_pending <= next_reload_pending;
      refresh_armed <= next_refresh_armed;
      in_prev <= next_in_prev;
      out_level <= next_out_level;
      eoc_q <= next_eoc_q;
      rdata_q <= next_rdata_q;
    end
  end

  // ----------------------------------------
  // Outputs and interrupt routing
  // ----------------------------------------
  assign rdata = rdata_q;
  // Held high when disabled so the pin can be shared
  assign timer_out = control[CTL_OUTPUT_ENABLE] ? out_level : 1'b1; // RQ11 RQ12
  assign events.timer_irq = eoc_q & ~wdog_mode; // RQ18
  assign events.system_reset = eoc_q & wdog_mode; // RQ14
  assign events.top_level = ext_int_vector_select[EXT_INT_VECTOR_SELECT_TOP_LEVEL_SOURCE_SEL] ? nmi_pin : events.timer_irq; // RQ15
  assign events.channel_zero = ext_int_vector_select[EXT_INT_VECTOR_SELECT_CHANNEL_ZERO_ROUTE] ? events.timer_irq : ext_int0_pin; // RQ16

endmodule

/* rtl/twd_pkg.sv */
// Package for the timer/watchdog register block: offsets, fields, reset values.
package twd_pkg;

  // ----------------------------------------
  // Register offsets in the register file page
  // ----------------------------------------
  localparam logic [7:0] ADDR_EXT_INT_VECTOR_SELECT = 8'hF6;
  localparam logic [7:0] ADDR_TIMER_COUNT_HIGH = 8'hF8;
  localparam logic [7:0] ADDR_TIMER_COUNT_LOW = 8'hF9;
  localparam logic [7:0] ADDR_TIMER_PRESCALE = 8'hFA;
  localparam logic [7:0] ADDR_TIMER_CONTROL = 8'hFB;
  localparam logic [7:0] ADDR_WAIT_CONTROL = 8'hFC;

  // ----------------------------------------
  // Control, wait control and vector select register fields
  // ----------------------------------------
  localparam int CTL_RUN_STOP = 7;
  localparam int CTL_SINGLE_CONTINUOUS = 6;
  localparam int CTL_INPUT_MODE_HI = 5;
  localparam int CTL_INPUT_MODE_LO = 4;
  localparam int CTL_INPUT_ENABLE = 3;
  localparam int CTL_OUTPUT_MODE = 2;
  localparam int CTL_USER_OUTPUT_VALUE = 1;
  localparam int CTL_OUTPUT_ENABLE = 0;
  localparam int WCR_WATCHDOG_ENABLE_N = 6;
  localparam int EXT_INT_VECTOR_SELECT_TOP_LEVEL_SOURCE_SEL = 2;
  localparam int EXT_INT_VECTOR_SELECT_CHANNEL_ZERO_ROUTE = 1;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] RST_TIMER_CONTROL = 8'h12;
  localparam logic [7:0] RST_WAIT_CONTROL = 8'h7F;
  localparam logic [7:0] RST_EXT_INT_VECTOR_SELECT = 8'h06;
  localparam logic [7:0] RST_UNDEFINED = 8'h00;

  // ----------------------------------------
  // Timing and refresh constants
  // ----------------------------------------
  localparam logic [1:0] INTERNAL_CLOCK_DIV_LAST = 2'h3;
  localparam logic [7:0] REFRESH_FIRST = 8'hAA;
  localparam logic [7:0] REFRESH_SECOND = 8'h55;

  // Input pin mode codes {hi, lo}
  localparam logic [1:0] IN_EVENT = 2'h0;
  localparam logic [1:0] IN_GATED = 2'h1;
  localparam logic [1:0] IN_TRIGGER = 2'h2;
  localparam logic [1:0] IN_RETRIGGER = 2'h3;

  // Register file access from the core
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } twd_bus_type;

  // Interrupt and reset requests leaving the block
  typedef struct packed {
    logic top_level;
    logic channel_zero;
    logic timer_irq;
    logic system_reset;
  } twd_event_type;

endpackage

/* testbench/twd_pin_model.sv */
// Model of the source wired to the timer input pin
module twd_pin_model (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [1:0] pin_mode,
  output logic pin
);
  logic [2:0] ph;
  // Free phase counter; a falling edge every 8 cycles stays well above the sampler's limit
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ph <= 3'h0;
    end else begin
      ph <= ph + 3'h1;
    end
  end
  // Mode 2 pulses, modes 0 and 1 hold a steady level
  assign pin = pin_mode[1] ? ph[2] : pin_mode[0];
endmodule

/* testbench/twd_asserts.sv */
// Concurrent checks on the timer/watchdog ports
module twd_asserts
  import twd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire twd_bus_type bus,
  input wire logic [7:0] rdata,
  input wire logic timer_in,
  input wire logic nmi_pin,
  input wire logic ext_int0_pin,
  input wire logic timer_out,
  input wire twd_event_type events
);
  logic [7:0] ext_int_vector_select;
  logic en;
  logic wdg_n;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  // Shadow of the software bits; watchdog entry can only be cleared, never set back
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ext_int_vector_select <= RST_EXT_INT_VECTOR_SELECT;
      en <= 1'b0;
      wdg_n <= 1'b1;
    end else if (bus.wr) begin
      if (bus.addr == ADDR_EXT_INT_VECTOR_SELECT) ext_int_vector_select <= bus.wdata;
      if (bus.addr == ADDR_TIMER_CONTROL) en <= bus.wdata[CTL_OUTPUT_ENABLE];
      if (bus.addr == ADDR_WAIT_CONTROL) wdg_n <= wdg_n & bus.wdata[WCR_WATCHDOG_ENABLE_N];
    end
  end
  // ----
  // Checks
  // ----
  chk_top_route: assert property (events.top_level == (ext_int_vector_select[2] ? nmi_pin : events.timer_irq))
    else $error("top level source wrong");
  chk_chan_route: assert property (events.channel_zero == (ext_int_vector_select[1] ? events.timer_irq : ext_int0_pin))
    else $error("channel zero source wrong");
  chk_irq_pulse: assert property (events.timer_irq |=> !events.timer_irq)
    else $error("interrupt pulse too long");
  chk_irq_quiet: assert property (!wdg_n |-> !events.timer_irq)
    else $error("interrupt in watchdog mode");
  chk_bite_mode: assert property (events.system_reset |-> !wdg_n && !events.timer_irq)
    else $error("system reset outside watchdog mode");
  chk_out_off: assert property (!en |-> timer_out)
    else $error("disabled output not high");
  chk_out_cause: assert property ($changed(timer_out) && $stable(en) |-> events.timer_irq || events.system_reset)
    else $error("output moved without end of count");
  chk_rd_hole: assert property (bus.rd && bus.addr == 8'hF7 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule
bind twd_timer_watchdog twd_asserts chk_u (.ref_clk(ref_clk), .srst(srst), .bus(bus), .rdata(rdata),
  .timer_in(timer_in), .nmi_pin(nmi_pin), .ext_int0_pin(ext_int0_pin), .timer_out(timer_out), .events(events));

/* testbench/tb_top.sv */
// Self-checking bench for the timer/watchdog block
module tb_top
  import twd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk;
  logic srst;
  twd_bus_type bus;
  logic [7:0] rdata;
  logic timer_in;
  logic nmi_pin;
  logic ext_int0_pin;
  logic timer_out;
  twd_event_type events;
  logic [1:0] pin_mode;
  logic [31:0] seed;
  logic [31:0] pseed = 32'hD3E4;
  logic [7:0] v;
  logic [7:0] w;
  logic [7:0] p;
  logic [7:0] c;
  logic o;
  int error_cnt;
  int checked;
  int cyc;
  int n;
  int rst_seen;
  // Generous ceiling; a clean run needs well under two thousand cycles
  localparam int CYC_LIMIT = 40000;
  twd_timer_watchdog dut_u (.ref_clk(ref_clk), .srst(srst), .bus(bus), .rdata(rdata), .timer_in(timer_in),
    .nmi_pin(nmi_pin), .ext_int0_pin(ext_int0_pin), .timer_out(timer_out), .events(events));
  twd_pin_model pin_u (.ref_clk(ref_clk), .srst(srst), .pin_mode(pin_mode), .pin(timer_in));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Expected cycles between two ends of count
  function automatic logic [15:0] period(input int div, input logic [7:0] pre, input logic [7:0] cnt);
    return 16'(div * (pre + 1) * (cnt + 1));
  endfunction

  // Repeatable pseudo-random source
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
    checked = checked + 1;
  endtask

  task automatic final_report();
    if (error_cnt == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Bus strobes change on falling edges and stand across one rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    bus = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge ref_clk);
    bus = '0;
  endtask

  // Read data is registered, so it stands at the following falling edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    bus = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge ref_clk);
    d = rdata;
    bus = '0;
  endtask

  // Counts falling edges up to the next interrupt pulse, bounded
  task automatic wait_irq(output int k);
    k = 0;
    do begin
      @(negedge ref_clk);
      k++;
    end while (!events.timer_irq && k < 3000);
  endtask

  // Constants written while stopped reach the counter at once
  task automatic load(input logic [7:0] pre, input logic [7:0] hi, input logic [7:0] lo);
    wr(ADDR_TIMER_CONTROL, 8'h00);
    wr(ADDR_TIMER_PRESCALE, pre);
    wr(ADDR_TIMER_COUNT_HIGH, hi);
    wr(ADDR_TIMER_COUNT_LOW, lo);
  endtask

  // ----------------------------------------
  // Clock, timeout and pulse monitor
  // ----------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // Sampled on falling edges so registered pulses have settled
  always @(negedge ref_clk) begin
    cyc = cyc + 1;
    if (events.system_reset) rst_seen = rst_seen + 1;
    if (cyc == CYC_LIMIT) begin
      error_cnt = error_cnt + 1;
      final_report();
    end
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    seed = pseed;
    bus = '0;
    nmi_pin = 1'b0;
    ext_int0_pin = 1'b0;
    pin_mode = 2'h1;
    srst = 1'b1;
    repeat (2) @(negedge ref_clk);
    srst = 1'b0;
    // Reset values and an unmapped hole
    rd(ADDR_TIMER_CONTROL, v);
    check("control after reset", v, 8'h12);
    rd(ADDR_WAIT_CONTROL, v);
    check("wait control after reset", v, 8'h7F);
    rd(8'hF7, v);
    check("unmapped read", v, 8'h00);
    check("output after reset", timer_out, 1'b1);
    seed = xs(seed);
    wr(ADDR_TIMER_PRESCALE, seed[7:0]);
    rd(ADDR_TIMER_PRESCALE, v);
    check("prescale readback", v, seed[7:0]);
    // Internal clock square wave, interrupt routed to both paths
    wr(ADDR_EXT_INT_VECTOR_SELECT, 8'h02);
    repeat (3) begin
      seed = xs(seed);
      p = {6'h00, seed[1:0]};
      c = {5'h00, seed[10:8]};
      load(p, 8'h00, c);
      wr(ADDR_TIMER_CONTROL, 8'h81);
      wait_irq(n);
      o = timer_out;
      wait_irq(n);
      check("square period", n, period(4, p, c));
      check("square toggle", timer_out, !o);
      check("top level irq", events.top_level, 1'b1);
      check("channel zero irq", events.channel_zero, 1'b1);
    end
    // PWM copies the user bit at end of count
    seed = xs(seed);
    wr(ADDR_TIMER_CONTROL, {5'b10000, 1'b1, seed[0], 1'b1});
    wait_irq(n);
    wait_irq(n);
    check("pwm output", timer_out, seed[0]);
    // Disabled output stays high while counting goes on
    wr(ADDR_TIMER_CONTROL, 8'h84);
    wait_irq(n);
    wait_irq(n);
    check("disabled output", timer_out, 1'b1);
    check("irq with output off", n, period(4, p, c));
    // Single count stops itself
    load(p, 8'h00, c);
    wr(ADDR_TIMER_CONTROL, 8'hC1);
    wait_irq(n);
    rd(ADDR_TIMER_CONTROL, v);
    check("single stop", v, 8'h41);
    // Live count reads and reload writes leave the counter running
    load(8'h00, 8'h12, 8'hFF);
    wr(ADDR_TIMER_CONTROL, 8'h80);
    rd(ADDR_TIMER_COUNT_LOW, w);
    repeat (8) @(negedge ref_clk);
    rd(ADDR_TIMER_COUNT_LOW, v);
    check("count moving", v < w, 1'b1);
    wr(ADDR_TIMER_COUNT_HIGH, 8'h00);
    rd(ADDR_TIMER_COUNT_HIGH, v);
    check("count kept on write", v, 8'h12);
    // Event counting on falling pin edges
    seed = xs(seed);
    p = {6'h00, seed[1:0]};
    c = {5'h00, seed[10:8]};
    load(p, 8'h00, c);
    pin_mode = 2'h2;
    wr(ADDR_TIMER_CONTROL, 8'h88);
    wait_irq(n);
    wait_irq(n);
    check("event period", n, period(8, p, c));
    // Gated by a high pin level
    load(8'h00, 8'h00, 8'h05);
    pin_mode = 2'h0;
    wr(ADDR_TIMER_CONTROL, 8'h98);
    repeat (100) @(negedge ref_clk);
    rd(ADDR_TIMER_COUNT_LOW, v);
    check("gated hold", v, 8'h05);
    pin_mode = 2'h1;
    wait_irq(n);
    wait_irq(n);
    check("gated period", n, period(4, 8'h00, 8'h05));
    // Trigger restarts a running count, retrigger starts a stopped one
    load(8'h00, 8'h00, 8'h20);
    pin_mode = 2'h2;
    wr(ADDR_TIMER_CONTROL, 8'hA8);
    repeat (200) @(negedge ref_clk);
    rd(ADDR_TIMER_COUNT_LOW, v);
    check("trigger restart", v >= 8'h1D, 1'b1);
    wr(ADDR_TIMER_CONTROL, 8'h38);
    repeat (20) @(negedge ref_clk);
    rd(ADDR_TIMER_CONTROL, v);
    check("retrigger start", v, 8'hB8);
    // Watchdog entry is sticky, refresh holds off the bite
    pin_mode = 2'h1;
    load(8'h00, 8'h00, 8'h10);
    wr(ADDR_WAIT_CONTROL, 8'h3F);
    rd(ADDR_WAIT_CONTROL, v);
    check("watchdog entry", v, 8'h3F);
    wr(ADDR_WAIT_CONTROL, 8'h7F);
    rd(ADDR_WAIT_CONTROL, v);
    check("watchdog sticky", v, 8'h3F);
    repeat (6) begin
      wr(ADDR_TIMER_COUNT_LOW, 8'hAA);
      wr(ADDR_TIMER_COUNT_LOW, 8'h55);
      repeat (30) @(negedge ref_clk);
    end
    check("no bite while fed", rst_seen, 16'h0000);
    n = 0;
    while (rst_seen == 0 && n < 200) begin
      @(negedge ref_clk);
      n++;
    end
    check("bite", rst_seen, 16'h0001);
    check("bite time", n <= period(4, 8'h00, 8'h10), 1'b1);
    // The bite comes back as a system reset in mid-run
    srst = 1'b1;
    repeat (2) @(negedge ref_clk);
    srst = 1'b0;
    rd(ADDR_WAIT_CONTROL, v);
    check("watchdog off after reset", v, 8'h7F);
    // External sources through the routing bits
    seed = xs(seed);
    wr(ADDR_EXT_INT_VECTOR_SELECT, 8'h04);
    nmi_pin = seed[0];
    @(negedge ref_clk);
    check("top level pin", events.top_level, seed[0]);
    wr(ADDR_EXT_INT_VECTOR_SELECT, 8'h00);
    ext_int0_pin = seed[1];
    @(negedge ref_clk);
    check("channel zero pin", events.channel_zero, seed[1]);
    final_report();
  end
endmodule
